// >>> include/flash_seq_pkg.sv
// Constants, enumerations and carriers shared by the flash erase/program sequencer.
package flash_seq_pkg;

  // Pageword and command limits.
  localparam int unsigned PW_BITS = 128;
  localparam logic [7:0] MAX_SECTOR = 8'h07;
  localparam logic [15:0] MAX_PROGRAM_BYTES = 16'h8000;
  localparam logic [15:0] PAGEWORD_STEP = 16'h0010;
  localparam logic [31:0] PAGEWORD_ADDR_STEP = 32'h0000_0010;
  localparam logic [7:0] EMPTY_MASK = 8'h00;

  // Sector size of the external parts as a byte shift: 4KB sectors, 32KB overlay blocks.
  localparam int unsigned EXT_SECTOR_SHIFT = 12;
  localparam int unsigned OVERLAY_SECTOR_SHIFT = 15;

  // Status byte bit that shows an external write or erase still in progress.
  localparam int unsigned STATUS_BUSY_BIT = 0;

  // Values after reset.
  localparam logic [15:0] PART_ID_RESET = 16'h0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Target memory currently selected.
  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_SUPPORTED = 3'b001,
    TGT_OVERLAY = 3'b010,
    TGT_CUSTOM = 3'b011,
    TGT_ON_CHIP = 3'b100
  } target_e;

  // Selection codes presented with a select strobe.
  typedef enum logic [2:0] {
    SUPPORTED_PART_SELECT = 3'b000,
    OVERLAY_PART_SELECT = 3'b001,
    CUSTOM_PART_SELECT = 3'b010,
    ON_CHIP_ARRAY_SELECT = 3'b011,
    AUTO_ON_CHIP_SELECT = 3'b100
  } sel_code_e;

  // Commands from the host.
  typedef enum logic [1:0] {
    CMD_SECTOR_ERASE = 2'b00,
    CMD_MULTI_ERASE = 2'b01,
    CMD_PROGRAM = 2'b10
  } cmd_op_e;

  // Operations issued on the flash port.
  typedef enum logic [3:0] {
    OP_IDLE = 4'h0,
    WRITE_ENABLE_PRIMITIVE = 4'h1,
    STATUS_READ_PRIMITIVE = 4'h2,
    STATUS_WRITE_PRIMITIVE = 4'h3,
    IDENTIFIER_READ_PRIMITIVE = 4'h4,
    PAGE_PROGRAM_PRIMITIVE = 4'h5,
    READ_PRIMITIVE = 4'h6,
    BULK_ERASE_PRIMITIVE = 4'h7,
    SECTOR_ERASE_PRIMITIVE = 4'h8,
    ARRAY_ERASE = 4'h9,
    ARRAY_PROGRAM = 4'ha,
    ARRAY_READ = 4'hb
  } fl_op_e;

  // Host command carrier.
  typedef struct packed {
    cmd_op_e op;
    logic [7:0] sector_number;
    logic [7:0] sector_erase_mask;
    logic [31:0] program_start_offset;
    logic [15:0] program_byte_count;
  } cmd_s;

  // Flash port request carrier.
  typedef struct packed {
    fl_op_e op;
    logic [31:0] addr;
    logic [7:0] sector;
    logic [PW_BITS-1:0] wdata;
  } fl_req_s;

endpackage : flash_seq_pkg

// >>> hw/flash_erase_program_sequencer.sv
// Sequencer that erases and programs the on-chip flash array or an external serial flash.
`timescale 1ns/10ps
//
// Overview of operation
// R1: Erase drives all-ones so every bit of the sector ends at one.
// R2: Single-sector erase accepts sector numbers zero through seven only.
// R3: On-chip multi-sector erase erases each sector whose mask bit is one.
// R4: Programming only clears bits; a zero bit is never turned back to one.
// R5: Host must erase the containing sector before programming it.
// R6: Program byte count is a multiple of sixteen, at most 0x8000.
// R7: Program start offset lies on a sixteen-byte boundary.
// R8: On-chip sectors are programmed one sixteen-byte pageword at a time.
// R9: Host must not program a pageword that is not blank.
// R10: A pageword read error raises the error interrupt.
// R11: Command addresses are byte offsets from the start of the selected flash.
// R12: A selection picks the target; switching targets needs a new selection.
// R13: Custom parts are driven only through the separate serial primitives.
// R14: The overlay part uses four 32KB blocks instead of 4KB sectors; the sequencer accepts overlay sector numbers zero through seven.
// R15: Every erase, multi-erase and program reports success or failure.
// R16: Host should avoid erasing sector zero, which holds program code.
// R17: Busy from acceptance to completion; no new command while busy.
module flash_erase_program_sequencer
  import flash_seq_pkg::*;
#(
  parameter int unsigned ONCHIP_SECTOR_SHIFT = 15
)(
  input wire logic ref_clk, // System clock, 100 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic sel_valid, // Target selection strobe.
  input wire sel_code_e sel_code, // Target selection code.
  input wire logic cmd_valid, // Command request.
  input wire cmd_s cmd, // Command fields.
  output logic cmd_ready, // Command taken when high with cmd_valid.
  output logic busy, // Operation in progress.
  output logic done_q, // One-cycle completion pulse.
  output logic ok_q, // Result of the last completion.
  output target_e target_q, // Currently selected target.
  output logic [15:0] part_id_q, // Identifier read from an external part.
  input wire logic pw_valid, // Program pageword offered.
  input wire logic [PW_BITS-1:0] pw_data, // Program pageword data.
  output logic pw_ready, // Pageword taken when high with pw_valid.
  output logic fl_req_q, // Flash port request, held until ack.
  output fl_req_s fl_q, // Flash port request fields.
  input wire logic fl_ack, // Flash port completion pulse.
  input wire logic fl_fail, // Failure flag with fl_ack.
  input wire logic fl_rd_err, // Pageword read error flag with fl_ack.
  input wire logic [PW_BITS-1:0] fl_rdata, // Read data with fl_ack.
  output logic err_irq_q // One-cycle error interrupt pulse.
);

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_IDENT = 4'h1,
    S_WRITE_ENABLE_PRIMITIVE = 4'h2,
    S_ERASE = 4'h3,
    S_POLL = 4'h4,
    S_DATA = 4'h5,
    S_RDPW = 4'h6,
    S_PROG = 4'h7,
    S_DONE = 4'h8
  } state_e;

  state_e state_q;
  state_e after_write_enable_primitive_q;
  fl_op_e next_op_q;
  cmd_op_e op_q;
  logic pass_q;
  logic [7:0] mask_q;
  logic [31:0] addr_q;
  logic [15:0] rem_q;
  logic [PW_BITS-1:0] pw_q;
  logic ext;
  logic accept;
  logic legal;

  ////////////////////////////////////////////////////////////////////////////////

  // Index of the lowest set mask bit; sectors are erased in rising order.
  function automatic logic [2:0] lowest_set(input logic [7:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (m[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : lowest_set

  // Byte offset of a sector, with the sector size of the selected target.
  function automatic logic [31:0] sector_base(input target_e t, input logic [7:0] s);
    logic [31:0] base;
    base = {24'h00_0000, s};
    case (t)
      TGT_OVERLAY: base = base << OVERLAY_SECTOR_SHIFT; // see R14
      TGT_ON_CHIP: base = base << ONCHIP_SECTOR_SHIFT;
      default: base = base << EXT_SECTOR_SHIFT;
    endcase
    return base;
  endfunction : sector_base

  ////////////////////////////////////////////////////////////////////////////////

  // Handshakes; a select strobe takes precedence over a command in the same cycle.
  assign ext = (target_q == TGT_SUPPORTED) || (target_q == TGT_OVERLAY) ||
               (target_q == TGT_CUSTOM);
  assign busy = (state_q != S_IDLE); // see R17
  assign cmd_ready = (state_q == S_IDLE) && !sel_valid; // see R17
  assign accept = cmd_valid && cmd_ready;
  assign pw_ready = (state_q == S_DATA);

  // Command checks; an illegal command completes at once with a failure.
  always_comb
  begin
    legal = 1'b0;
    case (cmd.op)
      CMD_SECTOR_ERASE: legal = (target_q != TGT_NONE) &&
                                (cmd.sector_number <= MAX_SECTOR); // see R2
      CMD_MULTI_ERASE: legal = (target_q == TGT_ON_CHIP); // see R3
      CMD_PROGRAM: legal = (target_q != TGT_NONE) &&
                           (cmd.program_byte_count != COUNT_RESET) &&
                           (cmd.program_byte_count[3:0] == 4'h0) &&
                           (cmd.program_byte_count <= MAX_PROGRAM_BYTES) && // see R6
                           (cmd.program_start_offset[3:0] == 4'h0); // see R7
      default: legal = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Sequencing and the flash port request. Each launch holds fl_req_q until fl_ack.
  // External writes need a write enable first and a status poll after, which
  // costs several port transactions per pageword but keeps the primitives generic.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= S_IDLE;
      after_write_enable_primitive_q <= S_IDLE;
      next_op_q <= OP_IDLE;
      op_q <= CMD_SECTOR_ERASE;
      pass_q <= 1'b0;
      mask_q <= EMPTY_MASK;
      addr_q <= ADDR_RESET;
      rem_q <= COUNT_RESET;
      pw_q <= '0;
      target_q <= TGT_NONE;
      part_id_q <= PART_ID_RESET;
      fl_req_q <= 1'b0;
      fl_q <= '0;
    end
    else
    begin
      if (fl_ack)
      begin
        fl_req_q <= 1'b0;
      end
      case (state_q)
        S_IDLE:
        begin
          if (sel_valid)
          begin
            // A new target only ever comes from a selection made while idle.
            pass_q <= 1'b1;
            state_q <= S_DONE;
            case (sel_code) // see R12
              SUPPORTED_PART_SELECT: target_q <= TGT_SUPPORTED;
              OVERLAY_PART_SELECT: target_q <= TGT_OVERLAY;
              CUSTOM_PART_SELECT: target_q <= TGT_CUSTOM;
              ON_CHIP_ARRAY_SELECT: target_q <= TGT_ON_CHIP;
              AUTO_ON_CHIP_SELECT: target_q <= TGT_ON_CHIP;
              default: target_q <= TGT_NONE;
            endcase
            if (sel_code <= CUSTOM_PART_SELECT)
            begin
              fl_req_q <= 1'b1;
              fl_q.op <= IDENTIFIER_READ_PRIMITIVE; // see R13
              state_q <= S_IDENT;
            end
          end
          else if (accept)
          begin
            op_q <= cmd.op;
            pass_q <= 1'b0;
            addr_q <= cmd.program_start_offset; // see R11
            rem_q <= cmd.program_byte_count;
            mask_q <= cmd.sector_erase_mask;
            if (!legal)
            begin
              state_q <= S_DONE;
            end
            else if (cmd.op == CMD_PROGRAM)
            begin
              state_q <= S_DATA;
            end
            else if (cmd.op == CMD_MULTI_ERASE && cmd.sector_erase_mask == EMPTY_MASK)
            begin
              pass_q <= 1'b1;
              state_q <= S_DONE;
            end
            else
            begin
              fl_req_q <= 1'b1;
              fl_q.wdata <= '1; // see R1
              if (cmd.op == CMD_MULTI_ERASE)
              begin
                fl_q.sector <= {5'h00, lowest_set(cmd.sector_erase_mask)}; // see R3
                fl_q.addr <= sector_base(target_q, {5'h00, lowest_set(cmd.sector_erase_mask)});
              end
              else
              begin
                fl_q.sector <= cmd.sector_number;
                fl_q.addr <= sector_base(target_q, cmd.sector_number);
              end
              if (ext)
              begin
                fl_q.op <= WRITE_ENABLE_PRIMITIVE; // see R13
                next_op_q <= SECTOR_ERASE_PRIMITIVE;
                after_write_enable_primitive_q <= S_ERASE;
                state_q <= S_WRITE_ENABLE_PRIMITIVE;
              end
              else
              begin
                fl_q.op <= ARRAY_ERASE;
                state_q <= S_ERASE;
              end
            end
          end
        end
        S_IDENT:
        begin
          if (fl_ack)
          begin
            part_id_q <= fl_rdata[15:0];
            pass_q <= !fl_fail;
            state_q <= S_DONE;
          end
        end
        S_WRITE_ENABLE_PRIMITIVE:
        begin
          if (fl_ack)
          begin
            fl_req_q <= !fl_fail;
            fl_q.op <= next_op_q;
            state_q <= fl_fail ? S_DONE : after_write_enable_primitive_q;
          end
        end
        S_DATA:
        begin
          if (pw_valid)
          begin
            // Read the pageword first so the write can never raise a bit.
            pw_q <= pw_data;
            fl_req_q <= 1'b1;
            fl_q.op <= ext ? READ_PRIMITIVE : ARRAY_READ;
            fl_q.addr <= addr_q; // see R8
            state_q <= S_RDPW;
          end
        end
        S_RDPW:
        begin
          if (fl_ack)
          begin
            fl_q.wdata <= fl_rdata & pw_q; // see R4
            fl_req_q <= !fl_fail;
            if (fl_fail)
            begin
              state_q <= S_DONE;
            end
            else if (ext)
            begin
              fl_q.op <= WRITE_ENABLE_PRIMITIVE;
              next_op_q <= PAGE_PROGRAM_PRIMITIVE;
              after_write_enable_primitive_q <= S_PROG;
              state_q <= S_WRITE_ENABLE_PRIMITIVE;
            end
            else
            begin
              fl_q.op <= ARRAY_PROGRAM;
              state_q <= S_PROG;
            end
          end
        end
        S_ERASE, S_PROG, S_POLL:
        begin
          if (fl_ack && fl_fail)
          begin
            state_q <= S_DONE; // see R15
          end
          else if (fl_ack && state_q != S_POLL && ext)
          begin
            fl_req_q <= 1'b1;
            fl_q.op <= STATUS_READ_PRIMITIVE;
            state_q <= S_POLL;
          end
          else if (fl_ack && state_q == S_POLL && fl_rdata[STATUS_BUSY_BIT])
          begin
            fl_req_q <= 1'b1;
          end
          else if (fl_ack && op_q == CMD_PROGRAM)
          begin
            if (rem_q == PAGEWORD_STEP)
            begin
              pass_q <= 1'b1;
              state_q <= S_DONE;
            end
            else
            begin
              rem_q <= rem_q - PAGEWORD_STEP;
              addr_q <= addr_q + PAGEWORD_ADDR_STEP; // see R8
              state_q <= S_DATA;
            end
          end
          else if (fl_ack)
          begin
            // Step through the remaining mask bits one sector at a time.
            if (op_q == CMD_MULTI_ERASE &&
                (mask_q & ~(8'h01 << fl_q.sector[2:0])) != EMPTY_MASK)
            begin
              mask_q <= mask_q & ~(8'h01 << fl_q.sector[2:0]);
              fl_req_q <= 1'b1;
              fl_q.op <= ARRAY_ERASE;
              fl_q.sector <= {5'h00, lowest_set(mask_q & ~(8'h01 << fl_q.sector[2:0]))};
              fl_q.addr <= sector_base(target_q,
                {5'h00, lowest_set(mask_q & ~(8'h01 << fl_q.sector[2:0]))}); // see R3
            end
            else
            begin
              mask_q <= EMPTY_MASK;
              pass_q <= 1'b1;
              state_q <= S_DONE;
            end
          end
        end
        S_DONE:
        begin
          state_q <= S_IDLE;
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Completion report, one pulse per command or selection.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      done_q <= 1'b0;
      ok_q <= 1'b0;
    end
    else
    begin
      done_q <= (state_q == S_DONE); // see R15
      if (state_q == S_DONE)
      begin
        ok_q <= pass_q;
      end
    end
  end

  // Error interrupt; a read error usually means a pageword was written while not blank.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      err_irq_q <= 1'b0;
    end
    else
    begin
      err_irq_q <= (state_q == S_RDPW) && fl_ack && fl_rd_err; // see R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Checks on the sequencer.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  sequence fail_report;
    (state_q == S_DONE) ##1 (done_q && !ok_q);
  endsequence

  chk_busy_refuse: assert property (busy |-> !cmd_ready) // see R17
    else $error("command accepted while busy");
  chk_sector_range: assert property ( // see R2
    accept && cmd.op == CMD_SECTOR_ERASE && cmd.sector_number > MAX_SECTOR |=> fail_report)
    else $error("out-of-range sector not failed");
  chk_multi_target: assert property ( // see R3
    accept && cmd.op == CMD_MULTI_ERASE && target_q != TGT_ON_CHIP |=> fail_report)
    else $error("multi-sector erase off-chip not failed");
  chk_count_legal: assert property ( // see R6
    accept && cmd.op == CMD_PROGRAM &&
    (cmd.program_byte_count[3:0] != 4'h0 || cmd.program_byte_count > MAX_PROGRAM_BYTES)
    |=> fail_report)
    else $error("bad byte count not failed");
  chk_offset_align: assert property ( // see R7
    accept && cmd.op == CMD_PROGRAM && cmd.program_start_offset[3:0] != 4'h0 |=> fail_report)
    else $error("misaligned offset not failed");
  chk_erase_ones: assert property ( // see R1
    fl_req_q && (fl_q.op == ARRAY_ERASE || fl_q.op == SECTOR_ERASE_PRIMITIVE) |-> &fl_q.wdata)
    else $error("erase data not all ones");
  chk_never_sets: assert property ( // see R4
    fl_req_q && (fl_q.op == ARRAY_PROGRAM || fl_q.op == PAGE_PROGRAM_PRIMITIVE)
    |-> (fl_q.wdata & ~pw_q) == '0)
    else $error("program would set a bit");
  chk_pageword_step: assert property ( // see R8
    state_q == S_PROG && fl_ack && !fl_fail && !ext && rem_q != PAGEWORD_STEP
    |=> addr_q == $past(addr_q) + PAGEWORD_ADDR_STEP ##0 state_q == S_DATA)
    else $error("pageword address not stepped");
  chk_read_irq: assert property ( // see R10
    state_q == S_RDPW && fl_ack && fl_rd_err |=> err_irq_q ##1 !err_irq_q)
    else $error("read error without interrupt");
  chk_offset_kept: assert property ( // see R11
    accept && cmd.op == CMD_PROGRAM |=> addr_q == $past(cmd.program_start_offset))
    else $error("offset altered on acceptance");
  chk_select_only: assert property ( // see R12
    target_q != $past(target_q) |-> $past(sel_valid) && $past(state_q) == S_IDLE)
    else $error("target changed without selection");
  chk_custom_prims: assert property ( // see R13
    target_q == TGT_CUSTOM && fl_req_q |-> fl_q.op != ARRAY_ERASE &&
    fl_q.op != ARRAY_PROGRAM && fl_q.op != ARRAY_READ)
    else $error("array op issued to custom part");
  chk_overlay_block: assert property ( // see R14
    target_q == TGT_OVERLAY && fl_req_q && fl_q.op == SECTOR_ERASE_PRIMITIVE
    |-> fl_q.addr[14:0] == 15'h0000)
    else $error("overlay erase not on 32KB block");
  chk_done_pulse: assert property (state_q == S_DONE |=> done_q ##1 !done_q) // see R15
    else $error("completion not a single pulse");

endmodule : flash_erase_program_sequencer

// >>> verif/flash_model.sv
// Behavioural flash array on the far side of the sequencer's flash port.
`timescale 1ns/10ps
module flash_model
  import flash_seq_pkg::*;
#(
  parameter logic [15:0] PART_ID = 16'h5a3c // Arbitrary identifier value.
)(
  input wire logic ref_clk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic fl_req_q, // Request from the sequencer.
  input wire fl_req_s fl_q, // Request fields.
  input wire logic fail_en, // Answer every op as failed.
  input wire logic slow, // Add wait cycles before each ack.
  output logic fl_ack, // One-cycle completion.
  output logic fl_fail, // Failure flag.
  output logic fl_rd_err, // Pageword read error.
  output logic [PW_BITS-1:0] fl_rdata // Read data.
);
  // Sectors of 16 pagewords: the bench runs the sequencer with 256-byte sectors.
  logic [PW_BITS-1:0] mem [0:127];
  int unsigned wait_cnt, erase_cnt, write_enable_primitive_cnt, polls;
  logic [31:0] last_addr;
  logic [6:0] idx;
  assign idx = fl_q.addr[10:4];
  //////////////////////////////////////////////////////////////////////////
  // Outside an ack the answer lines toggle, so stale data is never mistaken for new.
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {fl_ack, fl_fail, fl_rd_err, fl_rdata} <= '0;
      {wait_cnt, erase_cnt, write_enable_primitive_cnt, polls, last_addr} <= '0;
      for (int i = 0; i < 128; i++) mem[i] <= '1;
    end
    else
    begin
      fl_rdata <= ~fl_rdata;
      fl_fail <= ~fl_fail;
      fl_rd_err <= ~fl_rd_err;
      if (fl_ack)
        fl_ack <= 1'b0;
      else if (fl_req_q && wait_cnt < (slow ? 3 : 0))
        wait_cnt <= wait_cnt + 1;
      else if (fl_req_q)
      begin
        wait_cnt <= 0;
        fl_ack <= 1'b1;
        fl_fail <= fail_en;
        fl_rd_err <= 1'b0;
        case (fl_q.op)
          ARRAY_ERASE, SECTOR_ERASE_PRIMITIVE:
          begin
            erase_cnt <= erase_cnt + 1;
            last_addr <= fl_q.addr;
            polls <= 1;
            // Whole sector back to ones for ARRAY_ERASE; a SECTOR_ERASE_PRIMITIVE leaves mem as it is.
            if (fl_q.op == ARRAY_ERASE)
              for (int i = 0; i < 16; i++) mem[{fl_q.addr[10:8], i[3:0]}] <= '1;
          end
          ARRAY_READ, READ_PRIMITIVE:
          begin
            fl_rdata <= mem[idx];
            fl_rd_err <= (mem[idx] != '1);
          end
          ARRAY_PROGRAM, PAGE_PROGRAM_PRIMITIVE:
          begin
            mem[idx] <= fl_q.wdata; // Stored as given, so the merge is the sequencer's.
            polls <= 1;
          end
          WRITE_ENABLE_PRIMITIVE: write_enable_primitive_cnt <= write_enable_primitive_cnt + 1;
          STATUS_READ_PRIMITIVE:
          begin
            fl_rdata <= {{(PW_BITS-1){1'b0}}, polls != 0};
            if (polls != 0) polls <= polls - 1;
          end
          IDENTIFIER_READ_PRIMITIVE: fl_rdata <= {{(PW_BITS-16){1'b0}}, PART_ID};
          default: fl_rdata <= '0;
        endcase
      end
    end
  end
endmodule : flash_model

// >>> verif/tb_top.sv
// Self-checking bench for the flash erase/program sequencer.
`timescale 1ns/10ps
module tb_top
  import flash_seq_pkg::*;
;
  logic ref_clk = 1'b0, arst_n = 1'b0, sel_valid = 1'b0, cmd_valid = 1'b0, pw_valid = 1'b0;
  logic fail_en = 1'b0, slow = 1'b0;
  sel_code_e sel_code = SUPPORTED_PART_SELECT;
  cmd_s cmd = '0;
  logic [PW_BITS-1:0] pw_data = '0, fl_rdata;
  logic cmd_ready, busy, done_q, ok_q, pw_ready, fl_req_q, fl_ack, fl_fail, fl_rd_err, err_irq_q;
  target_e target_q;
  logic [15:0] part_id_q;
  fl_req_s fl_q;
  int mismatches = 0, samples_checked = 0, irq_cnt = 0, e0, w0;
  localparam logic [127:0] D = 128'hf0f0_1234_5678_9abc_def0_0f0f_a5a5_3c3c;
  localparam logic [127:0] D2 = 128'h0ff0_ffff_0000_ffff_1111_eeee_5a5a_c3c3;
  // Refused commands: sector 8, count 0, count not a multiple of sixteen, count over limit, unaligned offset.
  cmd_op_e ill_op [5] = '{CMD_SECTOR_ERASE, CMD_PROGRAM, CMD_PROGRAM, CMD_PROGRAM, CMD_PROGRAM};
  logic [7:0] ill_sec [5] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [31:0] ill_off [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0108};
  logic [15:0] ill_cnt [5] = '{16'h0, 16'h0, 16'h0018, 16'h8010, 16'h0010};

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (err_irq_q === 1'b1) irq_cnt++;

  flash_erase_program_sequencer #(.ONCHIP_SECTOR_SHIFT(8)) u_dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .sel_valid(sel_valid), .sel_code(sel_code), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .busy(busy), .done_q(done_q), .ok_q(ok_q),
    .target_q(target_q), .part_id_q(part_id_q), .pw_valid(pw_valid), .pw_data(pw_data),
    .pw_ready(pw_ready), .fl_req_q(fl_req_q), .fl_q(fl_q), .fl_ack(fl_ack), .fl_fail(fl_fail),
    .fl_rd_err(fl_rd_err), .fl_rdata(fl_rdata), .err_irq_q(err_irq_q));
  flash_model u_model (.ref_clk(ref_clk), .arst_n(arst_n), .fl_req_q(fl_req_q), .fl_q(fl_q),
    .fail_en(fail_en), .slow(slow), .fl_ack(fl_ack), .fl_fail(fl_fail), .fl_rd_err(fl_rd_err),
    .fl_rdata(fl_rdata));
  //////////////////////////////////////////////////////////////////////////
  // Shared compare, command, selection and closing tasks.
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Waits for the completion pulse under a bound; a hang shows up as done_q low.
  task automatic wait_done(input logic exp_ok);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (done_q !== 1'b1 && n < 3000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk({done_q, ok_q}, {1'b1, exp_ok});
  endtask : wait_done

  task automatic run(input cmd_op_e o, input logic [7:0] s, input logic [7:0] m,
    input logic [31:0] off, input logic [15:0] cnt, input int npw, input logic exp_ok);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= '{op: o, sector_number: s, sector_erase_mask: m, program_start_offset: off,
      program_byte_count: cnt};
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(negedge ref_clk);
    chk({busy, cmd_ready}, 2'b10);
    if (npw > 0) @(posedge ref_clk);
    for (int i = 0; i < npw; i++)
    begin
      pw_valid <= 1'b1;
      pw_data <= (i == 0) ? ((npw == 1 && off == 32'h110) ? D2 : D) : ~D;
      @(negedge ref_clk);
      while (pw_ready !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
    end
    if (npw > 0) pw_valid <= 1'b0;
    wait_done(exp_ok);
  endtask : run

  task automatic sel(input sel_code_e c, input target_e t);
    @(posedge ref_clk);
    sel_valid <= 1'b1;
    sel_code <= c;
    @(posedge ref_clk);
    sel_valid <= 1'b0;
    wait_done(1'b1);
    chk(target_q, t);
  endtask : sel

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the expected run of a few hundred cycles.
  initial
  begin
    #400000;
    mismatches++;
    give_verdict();
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    chk({target_q, ok_q, busy}, {TGT_NONE, 2'b00});
    sel(sel_code_e'(3'd5), TGT_NONE);
    run(CMD_SECTOR_ERASE, 8'h01, 8'h00, 32'h0, 16'h0, 0, 1'b0);
    sel(AUTO_ON_CHIP_SELECT, TGT_ON_CHIP);
    sel(ON_CHIP_ARRAY_SELECT, TGT_ON_CHIP);
    for (int i = 0; i < 5; i++)
    begin
      run(ill_op[i], ill_sec[i], 8'h00, ill_off[i], ill_cnt[i], 0, 1'b0);
    end
    $display("test setup and refusals done");
    // Sector 0 holds code, so work happens in sector 1, erased first.
    run(CMD_SECTOR_ERASE, 8'h01, 8'h00, 32'h0, 16'h0, 0, 1'b1);
    run(CMD_PROGRAM, 8'h00, 8'h00, 32'h0000_0110, 16'h0020, 2, 1'b1);
    chk(u_model.mem[17], D);
    chk(u_model.mem[18], ~D);
    chk(irq_cnt, 0);
    e0 = irq_cnt;
    run(CMD_PROGRAM, 8'h00, 8'h00, 32'h0000_0110, 16'h0010, 1, 1'b1);
    chk(u_model.mem[17], D & D2);
    chk(irq_cnt - e0, 1);
    run(CMD_SECTOR_ERASE, 8'h01, 8'h00, 32'h0, 16'h0, 0, 1'b1);
    chk(u_model.mem[17], {128{1'b1}});
    chk(u_model.mem[31], {128{1'b1}});
    e0 = u_model.erase_cnt;
    run(CMD_MULTI_ERASE, 8'h00, 8'h0a, 32'h0, 16'h0, 0, 1'b1);
    chk({u_model.erase_cnt - e0, u_model.last_addr}, {32'd2, 32'h0000_0300});
    run(CMD_MULTI_ERASE, 8'h00, 8'h00, 32'h0, 16'h0, 0, 1'b1);
    chk(u_model.erase_cnt - e0, 2);
    @(posedge ref_clk) fail_en <= 1'b1;
    run(CMD_SECTOR_ERASE, 8'h02, 8'h00, 32'h0, 16'h0, 0, 1'b0);
    @(posedge ref_clk) fail_en <= 1'b0;
    $display("test on-chip array done");
    @(posedge ref_clk) slow <= 1'b1;
    sel(CUSTOM_PART_SELECT, TGT_CUSTOM);
    chk(part_id_q, u_model.PART_ID);
    w0 = u_model.write_enable_primitive_cnt;
    run(CMD_SECTOR_ERASE, 8'h07, 8'h00, 32'h0, 16'h0, 0, 1'b1);
    chk({u_model.last_addr, u_model.write_enable_primitive_cnt - w0}, {32'h0000_7000, 32'd1});
    run(CMD_MULTI_ERASE, 8'h00, 8'h01, 32'h0, 16'h0, 0, 1'b0);
    run(CMD_PROGRAM, 8'h00, 8'h00, 32'h0000_0020, 16'h0010, 1, 1'b1);
    chk(u_model.mem[2], D);
    sel(OVERLAY_PART_SELECT, TGT_OVERLAY);
    run(CMD_SECTOR_ERASE, 8'h02, 8'h00, 32'h0, 16'h0, 0, 1'b1);
    chk(u_model.last_addr, 32'h0001_0000);
    sel(SUPPORTED_PART_SELECT, TGT_SUPPORTED);
    run(CMD_SECTOR_ERASE, 8'h03, 8'h00, 32'h0, 16'h0, 0, 1'b1);
    chk(u_model.last_addr, 32'h0000_3000);
    $display("test external parts done");
    give_verdict();
  end
endmodule : tb_top
